// file: logic/hir_host_irq.sv
`timescale 1ns/1ps
// How it works
// - serial reads shift out on sdo
// - sdo edge chosen by shift_edge_select pin
// - one request output for all sources
// - global mask bit silences the request
// - two mask registers block single sources
// - summary and status registers readable
// - two-bit field picks request pin style
// - 8-bit address selects the register
// - reset after pin low for 4 clocks (160 ns)
// - reset tristates the line drivers
// - reset restores register defaults
module hir_host_irq
    import hir_pkg::*;
(
    input  wire logic                core_clk,          // 25 MHz clock
    input  wire logic                rst_n,             // reset pin
    input  wire logic                serial_mode,       // 1 serial port
    input  wire logic                cs_n,              // chip select
    input  wire logic                shift_clk,         // serial clock
    input  wire logic                serial_in_pin,     // sdi / read-write
    input  wire logic                shift_edge_select, // sdo edge
    input  wire logic                data_strobe_n,     // parallel strobe
    input  wire logic [7:0]          host_address_bus,  // register address
    input  wire logic [7:0]          data_in,           // parallel data in
    input  wire logic [NUM_SRC-1:0]  irq_src,           // pending sources
    output logic      [7:0]          data_out,          // parallel data out
    output logic                     data_oe,           // data bus enable
    output logic                     serial_out_pin,    // sdo level
    output logic                     serial_out_oe,     // sdo enable
    output logic                     irq_out,           // request level
    output logic                     irq_oe,            // request enable
    output logic                     line_drv_hiz       // line drivers off
);

    // pin synchronisers; the reset pin flops carry no reset
    logic       rst_s1, rst_s2;
    logic [5:0] ctl_s1, ctl_s2;
    logic [7:0] adr_s1, adr_s2;
    logic [7:0] din_s1, din_s2;
    logic       sclk_s3, ds_s3;

    always_ff @(posedge core_clk)
    begin
        rst_s1 <= rst_n;
        rst_s2 <= rst_s1;
        ctl_s1 <= {serial_mode, cs_n, shift_clk, serial_in_pin,
                   shift_edge_select, data_strobe_n};
        ctl_s2 <= ctl_s1;
        adr_s1 <= host_address_bus;
        adr_s2 <= adr_s1;
        din_s1 <= data_in;
        din_s2 <= din_s1;
        sclk_s3 <= ctl_s2[3];
        ds_s3 <= ctl_s2[0];
    end

    wire ser_s  = ctl_s2[5];
    wire cs_s_n = ctl_s2[4];
    wire sclk_s = ctl_s2[3];
    wire sdi_s  = ctl_s2[2];
    wire sel_s  = ctl_s2[1];
    wire ds_s_n = ctl_s2[0];

    // reset filter: short glitches on the pin are ignored
    // shift history, not a counter: an unknown count at power-up
    // would never clear, while shifted lows flush it out
    logic [RST_CYC_INT-1:0] rst_low;
    logic                   in_reset;

    always_ff @(posedge core_clk)
    begin
        rst_low <= {rst_low[RST_CYC_INT-2:0], ~rst_s2};
        in_reset <= &{rst_low, ~rst_s2};
    end

    // registers
    logic [7:0] mask_lo, mask_hi, gcfg;
    logic       wr_en;
    logic [7:0] wr_addr, wr_data;

    always_ff @(posedge core_clk)
    begin
        if (in_reset)
        begin
            mask_lo <= MASK_RST;
            mask_hi <= MASK_RST;
            gcfg <= GCFG_RST;
        end
        else if (wr_en)
        begin
            if (wr_addr == OFF_MASK_LO)
                mask_lo <= wr_data;
            if (wr_addr == OFF_MASK_HI)
                mask_hi <= wr_data;
            if (wr_addr == OFF_GCFG)
                gcfg <= wr_data & GCFG_WMASK;
        end
    end

    wire [NUM_SRC-1:0] pend = irq_src & ~{mask_hi, mask_lo};
    wire [1:0]         pin_mode = gcfg[GCFG_PIN_LSB +: 2];
    wire               gmask = gcfg[GCFG_GMASK];
    wire  [7:0]        summary;

    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++)
        begin : g_summ
            if (ch < NUM_CH)
            begin : g_used
                assign summary[ch] = |pend[ch*SRC_PER_CH +: SRC_PER_CH];
            end
            else
            begin : g_free
                assign summary[ch] = 1'b0;
            end
        end
    endgenerate

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        case (a)
            OFF_MASK_LO: rd_mux = mask_lo;
            OFF_MASK_HI: rd_mux = mask_hi;
            OFF_STS_LO:  rd_mux = irq_src[7:0];
            OFF_STS_HI:  rd_mux = irq_src[15:8];
            OFF_GCFG:    rd_mux = gcfg;
            OFF_CH_SUMM: rd_mux = summary;
            default:     rd_mux = BYTE_ZERO;
        endcase
    endfunction

    // serial port
    wire sclk_rise = sclk_s & ~sclk_s3;
    wire sclk_fall = ~sclk_s & sclk_s3;
    wire ds_rise   = ds_s_n & ~ds_s3;
    logic [4:0] ser_cnt;
    logic       ser_rw, ser_load;
    logic [7:0] ser_addr, ser_wdat, rd_sh;

    wire sclk_chg = sel_s ? sclk_fall : sclk_rise;
    // an access lives only while cs is low
    wire ser_act  = ser_s & ~cs_s_n;
    wire [7:0] ser_addr_nx = {sdi_s, ser_addr[7:1]};
    wire [7:0] ser_wdat_nx = {sdi_s, ser_wdat[7:1]};
    wire ser_wr = ser_act & sclk_rise & ~ser_rw
                  & (ser_cnt == SER_DATA_LAST);
    wire par_wr = ~ser_s & ~cs_s_n & ~sdi_s & ds_rise;

    assign wr_en   = ser_wr | par_wr;
    assign wr_addr = ser_wr ? ser_addr : adr_s2;
    assign wr_data = ser_wr ? ser_wdat_nx : din_s2;

    always_ff @(posedge core_clk)
    begin
        if (in_reset || !ser_act)
        begin
            ser_cnt <= SER_CNT_ZERO;
            ser_rw <= 1'b0;
            ser_load <= 1'b0;
            ser_addr <= BYTE_ZERO;
            ser_wdat <= BYTE_ZERO;
            rd_sh <= BYTE_ZERO;
        end
        else if (sclk_rise && ser_cnt != SER_DONE)
        begin
            ser_cnt <= ser_cnt + SER_CNT_ONE;
            if (ser_cnt == SER_CNT_ZERO)
                ser_rw <= sdi_s;
            else if (ser_cnt <= SER_ADDR_LAST)
                ser_addr <= ser_addr_nx;
            else
                ser_wdat <= ser_wdat_nx;
            // read data captured once the address is complete
            if (ser_cnt == SER_ADDR_LAST && ser_rw)
            begin
                rd_sh <= rd_mux(ser_addr_nx);
                ser_load <= 1'b1;
            end
            else if (sclk_chg && ser_load)
                rd_sh <= rd_sh >> 1;
        end
        else if (sclk_chg && ser_load)
            rd_sh <= rd_sh >> 1;
    end

    // outputs, all registered
    logic irq_act;
    wire  any_pend = (|pend) & ~gmask;

    always_ff @(posedge core_clk)
    begin
        if (in_reset)
        begin
            serial_out_pin <= 1'b0;
            serial_out_oe <= 1'b0;
            data_out <= BYTE_ZERO;
            data_oe <= 1'b0;
            irq_act <= 1'b0;
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
            line_drv_hiz <= 1'b1;
        end
        else
        begin
            line_drv_hiz <= 1'b0;
            if (sclk_chg && ser_load && ser_act)
                serial_out_pin <= rd_sh[0];
            serial_out_oe <= ser_act & ser_load;
            data_out <= rd_mux(adr_s2);
            data_oe <= ~ser_s & ~cs_s_n & ~ds_s_n & sdi_s;
            irq_act <= any_pend;
            case (pin_mode)
                PIN_OD_LOW:
                begin
                    irq_out <= 1'b0;
                    irq_oe <= any_pend;
                end
                PIN_PP_LOW:
                begin
                    irq_out <= ~any_pend;
                    irq_oe <= 1'b1;
                end
                default:
                begin
                    irq_out <= any_pend;
                    irq_oe <= 1'b1;
                end
            endcase
        end
    end

    // checks
    a_reset_filter_hold:
    assert property (@(posedge core_clk)
        !rst_s2 [*4] |=> in_reset)
    else $error("reset pin low too long without reset");

    a_reset_short_pulse:
    assert property (@(posedge core_clk)
        rst_s2 ##1 !rst_s2 ##1 rst_s2 |=> !in_reset)
    else $error("short reset pulse was not filtered");

    a_reset_drv_state:
    assert property (@(posedge core_clk)
        in_reset |=> line_drv_hiz && !serial_out_oe && !data_oe)
    else $error("drivers not released during reset");

    a_reset_reg_defaults:
    assert property (@(posedge core_clk)
        in_reset |=> mask_lo == MASK_RST && mask_hi == MASK_RST
                     && gcfg == GCFG_RST)
    else $error("registers not at defaults after reset");

    a_global_mask_quiet:
    assert property (@(posedge core_clk) disable iff (in_reset)
        gmask |=> !irq_act)
    else $error("request raised under global mask");

    a_any_source_req:
    assert property (@(posedge core_clk) disable iff (in_reset)
        !gmask && (|(irq_src & ~{mask_hi, mask_lo})) |=> irq_act)
    else $error("pending source did not raise request");

    a_mask_blocks_src:
    assert property (@(posedge core_clk) disable iff (in_reset)
        (irq_src & ~{mask_hi, mask_lo}) == 16'h0000 |=> !irq_act)
    else $error("masked source reached request");

    a_open_drain_idle:
    assert property (@(posedge core_clk) disable iff (in_reset)
        $stable(gcfg) && pin_mode == PIN_OD_LOW
        |-> irq_oe == irq_act && !irq_out)
    else $error("open drain request driven wrongly");

    a_push_low_level:
    assert property (@(posedge core_clk) disable iff (in_reset)
        $stable(gcfg) && pin_mode == PIN_PP_LOW
        |-> irq_oe && irq_out == !irq_act)
    else $error("push-pull low request level wrong");

    a_status_read_back:
    assert property (@(posedge core_clk) disable iff (in_reset)
        data_oe && adr_s2 == OFF_STS_LO && $stable(adr_s2)
        && $stable(irq_src) |-> data_out == irq_src[7:0])
    else $error("status byte read back wrong");

    a_write_mask_lo:
    assert property (@(posedge core_clk) disable iff (in_reset)
        wr_en && wr_addr == OFF_MASK_LO |=> mask_lo == $past(wr_data))
    else $error("write to mask register lost");

    a_sdo_active_edge:
    assert property (@(posedge core_clk) disable iff (in_reset)
        $past(serial_out_oe) && serial_out_oe && $changed(serial_out_pin)
        |-> $past(sclk_chg))
    else $error("sdo changed off its active edge");

    a_sdo_fall_only:
    assert property (@(posedge core_clk) disable iff (in_reset)
        $past(sel_s) && serial_out_oe && $changed(serial_out_pin)
        |-> $past(sclk_fall))
    else $error("sdo changed on rising edge with select high");

endmodule

// file: shared/hir_pkg.sv
package hir_pkg;

    // register offsets on the 8-bit address bus
    localparam logic [7:0] OFF_MASK_LO   = 8'h11;
    localparam logic [7:0] OFF_MASK_HI   = 8'h12;
    localparam logic [7:0] OFF_STS_LO    = 8'h16;
    localparam logic [7:0] OFF_STS_HI    = 8'h17;
    localparam logic [7:0] OFF_GCFG      = 8'h40;
    localparam logic [7:0] OFF_CH_SUMM   = 8'h80;

    // global_config fields
    localparam int         GCFG_PIN_LSB  = 0;
    localparam int         GCFG_GMASK    = 2;
    localparam int         GCFG_T1E1     = 3;
    localparam logic [7:0] GCFG_WMASK    = 8'h0F;

    // request pin characteristics
    localparam logic [1:0] PIN_OD_LOW    = 2'h0;
    localparam logic [1:0] PIN_PP_LOW    = 2'h1;
    localparam logic [1:0] PIN_PP_HIGH   = 2'h2;

    // reset values
    localparam logic [7:0] MASK_RST      = 8'hFF;
    localparam logic [7:0] GCFG_RST      = 8'h00;
    localparam logic [7:0] BYTE_ZERO     = 8'h00;

    // sources: four channels of four sources each
    localparam int         NUM_CH        = 4;
    localparam int         SRC_PER_CH    = 4;
    localparam int         NUM_SRC       = 16;

    // serial frame: rw bit, 8 address bits, 8 data bits, lsb first
    localparam logic [4:0] SER_ADDR_LAST = 5'h08;
    localparam logic [4:0] SER_DATA_LAST = 5'h10;
    localparam logic [4:0] SER_DONE      = 5'h11;
    localparam logic [4:0] SER_CNT_ZERO  = 5'h00;
    localparam logic [4:0] SER_CNT_ONE   = 5'h01;

    // reset pin filter
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         RST_MIN_NS    = 100;
    localparam int         RST_CYC_INT   =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] RST_CYC       = RST_CYC_INT[2:0];

endpackage

// file: tb/hir_host_model.sv
`timescale 1ns/1ps
module hir_host_model
(
    input  wire logic       core_clk,          // bench clock
    input  wire logic       shift_edge_select, // sdo edge in use
    input  wire logic [7:0] data_out,          // device read data
    input  wire logic       data_oe,           // device drives data
    input  wire logic       serial_out_pin,    // serial read data
    output logic            cs_n,              // chip select
    output logic            shift_clk,         // serial clock
    output logic            serial_in_pin,     // serial data or rw
    output logic            data_strobe_n,     // parallel strobe
    output logic [7:0]      host_address_bus,  // register address
    output logic [7:0]      data_in,           // write data
    output logic            rd_valid,          // read value taken
    output logic [7:0]      rd_data            // read value
);
    initial
    begin
        cs_n = 1'b1;
        shift_clk = 1'b0;
        serial_in_pin = 1'b0;
        data_strobe_n = 1'b1;
        host_address_bus = 8'h00;
        data_in = 8'h00;
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic par(input logic rw, input logic [7:0] a,
                       input logic [7:0] d);
        tk(1);
        cs_n = 1'b0;
        serial_in_pin = rw;
        host_address_bus = a;
        data_in = d;
        data_strobe_n = 1'b0;
        tk(5);
        rd_data = (data_oe === 1'b1) ? data_out : 8'hXX;
        rd_valid = rw;
        data_strobe_n = 1'b1;
        tk(1);
        rd_valid = 1'b0;
        tk(4);
        cs_n = 1'b1;
        // released bus shows the inverse, not a stale value
        host_address_bus = ~a;
        data_in = ~d;
        tk(4);
    endtask

    task automatic ser(input logic rw, input logic [7:0] a,
                       input logic [7:0] d);
        logic [16:0] f;
        int          k;
        f = {d, a, rw};
        tk(1);
        cs_n = 1'b0;
        for (k = 0; k < 17; k++)
        begin
            serial_in_pin = f[k];
            tk(4);
            if (shift_edge_select && k > 8) rd_data[k-9] = serial_out_pin;
            shift_clk = 1'b1;
            tk(4);
            if (!shift_edge_select && k > 8) rd_data[k-9] = serial_out_pin;
            shift_clk = 1'b0;
        end
        rd_valid = rw;
        tk(1);
        rd_valid = 1'b0;
        cs_n = 1'b1;
        serial_in_pin = ~f[16];
        tk(4);
    endtask
endmodule

// file: tb/host_interrupt_and_reset_bench.sv
`timescale 1ns/1ps
module host_interrupt_and_reset_bench;
    import hir_pkg::*;
    logic               core_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               serial_mode = 1'b0;
    logic               shift_edge_select = 1'b0;
    logic [NUM_SRC-1:0] irq_src = '0;
    logic [15:0]        msk;
    logic [7:0]         v;
    logic [31:0]        seed = 32'h4D71E9FA;
    logic [7:0]         exp_q[$];
    int                 n_errors = 0;
    int                 n_compared = 0;
    int                 it;
    int                 n;
    wire                cs_n, shift_clk, serial_in_pin, data_strobe_n;
    wire  [7:0]         host_address_bus, data_in, data_out, rd_data;
    wire                data_oe, serial_out_pin, serial_out_oe, rd_valid;
    wire                irq_out, irq_oe, line_drv_hiz;
    wire  [7:0]         drv_state;

    assign drv_state = {4'h0, line_drv_hiz, irq_oe, data_oe, serial_out_oe};

    always #20 core_clk = ~core_clk;

    hir_host_irq i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .serial_mode(serial_mode), .cs_n(cs_n), .shift_clk(shift_clk),
        .serial_in_pin(serial_in_pin),
        .shift_edge_select(shift_edge_select),
        .data_strobe_n(data_strobe_n), .host_address_bus(host_address_bus),
        .data_in(data_in), .irq_src(irq_src), .data_out(data_out),
        .data_oe(data_oe), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .irq_out(irq_out), .irq_oe(irq_oe),
        .line_drv_hiz(line_drv_hiz));

    hir_host_model i_host (.core_clk(core_clk),
        .shift_edge_select(shift_edge_select), .data_out(data_out),
        .data_oe(data_oe), .serial_out_pin(serial_out_pin), .cs_n(cs_n),
        .shift_clk(shift_clk), .serial_in_pin(serial_in_pin),
        .data_strobe_n(data_strobe_n), .host_address_bus(host_address_bus),
        .data_in(data_in), .rd_valid(rd_valid), .rd_data(rd_data));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (serial_mode) i_host.ser(1'b0, a, d);
        else i_host.par(1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        if (serial_mode) i_host.ser(1'b1, a, 8'h00);
        else i_host.par(1'b1, a, 8'h00);
    endtask

    task automatic irq_chk(input logic [3:0] g);
        logic       req;
        logic [1:0] e;
        req = (|(irq_src & ~msk)) && !g[GCFG_GMASK];
        e = (g[1:0] == PIN_OD_LOW) ? {req, 1'b0} :
            (g[1:0] == PIN_PP_LOW) ? {1'b1, !req} : {1'b1, req};
        tick(4);
        check({6'h00, irq_oe, irq_out}, {6'h00, e});
    endtask

    always @(posedge core_clk)
        if (rd_valid === 1'b1)
            check(rd_data,
                  exp_q.size() ? exp_q.pop_front() : 8'hXX);

    // generous bound: full sequence needs well under a tenth of it
    initial
    begin
        #2000000;
        n_errors++;
        finish_test;
    end

    initial
    begin
        tick(9);
        check(drv_state, 8'h08);
        tick(1);
        rst_n = 1'b1;
        tick(8);
        check(drv_state, 8'h00);
        rd(OFF_MASK_LO, MASK_RST);
        rd(OFF_MASK_HI, MASK_RST);
        rd(OFF_GCFG, GCFG_RST);
        rd(8'h55, BYTE_ZERO);
        for (it = 0; it < 3; it++)
        begin
            seed = xs(seed);
            irq_src = seed[31:16];
            msk = (it == 0) ? 16'h0000 :
                  (it == 1) ? seed[15:0] : ~seed[31:16];
            wr(OFF_MASK_LO, msk[7:0]);
            wr(OFF_MASK_HI, msk[15:8]);
            rd(OFF_MASK_HI, msk[15:8]);
            rd(OFF_STS_LO, irq_src[7:0]);
            rd(OFF_STS_HI, irq_src[15:8]);
            for (n = 0; n < 4; n++)
                v[n] = |(irq_src[4*n+:4] & ~msk[4*n+:4]);
            rd(OFF_CH_SUMM, {4'h0, v[3:0]});
            for (n = 0; n < 8; n++)
            begin
                wr(OFF_GCFG, n[7:0]);
                irq_chk(n[3:0]);
            end
        end
        serial_mode = 1'b1;
        for (n = 0; n < 2; n++)
        begin
            shift_edge_select = n[0];
            tick(4);
            seed = xs(seed);
            v = seed[7:0] & GCFG_WMASK;
            wr(OFF_GCFG, v);
            rd(OFF_GCFG, v);
            rd(OFF_STS_HI, irq_src[15:8]);
        end
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(8);
        rd(OFF_GCFG, v);
        rst_n = 1'b0;
        tick(10);
        check(drv_state, 8'h08);
        rst_n = 1'b1;
        tick(8);
        check(drv_state, 8'h00);
        rd(OFF_GCFG, GCFG_RST);
        rd(OFF_MASK_LO, MASK_RST);
        tick(4);
        check(8'(exp_q.size()), 8'h00);
        finish_test;
    end
endmodule
